/* hdl/coincidence_voter.sv */
/*
 * registered m-of-n coincidence vote over redundant channel comparisons.
 * assumes channel inputs are synchronous booleans; one cycle of latency.
 */
`timescale 1ns/1ps
module coincidence_voter
    import vote_pkg::*;
#(
    parameter int N_CHAN = CHAN_COUNT,
    parameter int NEED   = VOTE_NEED
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // channel comparisons
    input  wire logic [N_CHAN-1:0] chan_trip,
    // coincidence result
    output logic                   vote
);

    localparam int TW = $clog2(N_CHAN + 1);
    localparam logic [TW-1:0] NEED_W = TW'(NEED);

    typedef struct packed {
        logic vote;
    } voter_state_t;

    voter_state_t state_ff;
    voter_state_t nxt_state;
    logic [TW-1:0] tally;

    always_comb begin
        tally = '0;
        for (int i = 0; i < N_CHAN; i++) begin
            if (chan_trip[i]) begin
                tally = tally + 1'b1;
            end
        end
        nxt_state      = state_ff;
        nxt_state.vote = (tally >= NEED_W);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff.vote <= VOTE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign vote = state_ff.vote;

endmodule

/* hdl/manual_bypass.sv */
/*
 * operator-established operating bypasses held under one permissive.
 * assumes requests are synchronous level or pulse inputs; permit is a registered vote.
 */
`timescale 1ns/1ps
module manual_bypass
    import vote_pkg::*;
#(
    parameter int W = BYP_PER_PERMIT
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // permissive and operator controls
    input  wire logic         permit,
    input  wire logic [W-1:0] req,
    input  wire logic [W-1:0] clr,
    // held bypasses
    output logic      [W-1:0] byp
);

    typedef struct packed {
        logic [W-1:0] byp;
    } bypass_state_t;

    bypass_state_t state_ff;
    bypass_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (!permit) begin
            // losing the permissive drops everything, no operator action
            nxt_state.byp = '0;
        end else begin
            // a request in the cycle of a clear still sets
            nxt_state.byp = (state_ff.byp & ~clr) | req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff.byp <= {W{BYPASS_RST}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign byp = state_ff.byp;

endmodule

/* hdl/power_interlock_permissive_voter.sv */
/*
 * neutron-power permissives and interlocks from 3-of-4 channel votes,
 * with operator and automatic operating bypasses for the trip logic.
 * assumes all inputs synchronous to ref_clk; outputs feed trip/actuation logic.
 */
`timescale 1ns/1ps
module power_interlock_permissive_voter
    import vote_pkg::*;
#(
    parameter int N_CHAN = CHAN_COUNT,
    parameter int NEED   = VOTE_NEED
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // channel comparisons
    input  wire logic [N_CHAN-1:0] ir_above_decade,
    input  wire logic [N_CHAN-1:0] pr_above_15pct,
    input  wire logic [N_CHAN-1:0] pr_below_15pct,
    // high linear power setpoint comparisons
    input  wire logic              lin_hi1_exceed,
    input  wire logic              lin_hi2_exceed,
    // operator bypass controls under the intermediate-range permissive
    input  wire logic              src_count_byp_req,
    input  wire logic              src_rate_byp_req,
    input  wire logic              ir_byp_clr,
    // operator bypass controls under the linear power permissive
    input  wire logic              hi1_lin_byp_req,
    input  wire logic              ir_rate_byp_req,
    input  wire logic              lin_byp_clr,
    // permissive and interlock states
    output logic                   ir_permissive,
    output logic                   ir_interlock,
    output logic                   linear_power_above_vote,
    output logic                   linear_power_below_vote,
    // bypass qualifiers to the trip and actuation logic
    output logic                   byp_src_count_trip,
    output logic                   byp_src_rate_trip,
    output logic                   byp_hi1_lin_trip,
    output logic                   byp_ir_rate_trip,
    output logic                   byp_dw_isol_subcritical_multiplication,
    output logic                   byp_pr_pos_rate_trip,
    output logic                   byp_pr_neg_rate_trip,
    // effective high linear power trip
    output logic                   lin_high_trip
);

    typedef struct packed {
        logic ir_perm;
        logic lin_above;
        logic lin_below;
        logic src_count;
        logic src_rate;
        logic hi1_lin;
        logic ir_rate;
        logic dw_scm;
        logic pr_pos;
        logic pr_neg;
        logic lin_trip;
    } top_state_t;

    top_state_t state_ff;
    top_state_t nxt_state;

    logic                      ir_vote;
    logic                      above_vote;
    logic                      below_vote;
    logic [BYP_PER_PERMIT-1:0] ir_req;
    logic [BYP_PER_PERMIT-1:0] ir_clr;
    logic [BYP_PER_PERMIT-1:0] ir_byp;
    logic [BYP_PER_PERMIT-1:0] lin_req;
    logic [BYP_PER_PERMIT-1:0] lin_clr;
    logic [BYP_PER_PERMIT-1:0] lin_byp;

    // one voter per instrument condition, each re-run every cycle
    coincidence_voter #(
        .N_CHAN (N_CHAN),
        .NEED   (NEED)
    ) u_ir_vote (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .chan_trip (ir_above_decade),
        .vote      (ir_vote)
    );

    coincidence_voter #(
        .N_CHAN (N_CHAN),
        .NEED   (NEED)
    ) u_above_vote (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .chan_trip (pr_above_15pct),
        .vote      (above_vote)
    );

    // below uses its own comparisons; a failed channel may sit in neither set
    coincidence_voter #(
        .N_CHAN (N_CHAN),
        .NEED   (NEED)
    ) u_below_vote (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .chan_trip (pr_below_15pct),
        .vote      (below_vote)
    );

    always_comb begin
        ir_req                   = '0;
        ir_req[IR_BYP_SRC_COUNT] = src_count_byp_req;
        ir_req[IR_BYP_SRC_RATE]  = src_rate_byp_req;
        ir_clr                   = {BYP_PER_PERMIT{ir_byp_clr}};
        lin_req                  = '0;
        lin_req[LIN_BYP_HI1]     = hi1_lin_byp_req;
        lin_req[LIN_BYP_IR_RATE] = ir_rate_byp_req;
        lin_clr                  = {BYP_PER_PERMIT{lin_byp_clr}};
    end

    manual_bypass #(
        .W (BYP_PER_PERMIT)
    ) u_ir_manual (
        .ref_clk (ref_clk),
        .rst     (rst),
        .permit  (ir_vote),
        .req     (ir_req),
        .clr     (ir_clr),
        .byp     (ir_byp)
    );

    manual_bypass #(
        .W (BYP_PER_PERMIT)
    ) u_lin_manual (
        .ref_clk (ref_clk),
        .rst     (rst),
        .permit  (above_vote),
        .req     (lin_req),
        .clr     (lin_clr),
        .byp     (lin_byp)
    );

    always_comb begin
        nxt_state           = state_ff;
        nxt_state.ir_perm   = ir_vote;
        nxt_state.lin_above = above_vote;
        nxt_state.lin_below = below_vote;
        // gating by the live vote removes a held bypass a cycle earlier
        nxt_state.src_count = ir_byp[IR_BYP_SRC_COUNT] & ir_vote;
        nxt_state.src_rate  = ir_byp[IR_BYP_SRC_RATE] & ir_vote;
        nxt_state.hi1_lin   = lin_byp[LIN_BYP_HI1] & above_vote;
        nxt_state.ir_rate   = (lin_byp[LIN_BYP_IR_RATE] & above_vote)
                            | above_vote;
        nxt_state.dw_scm    = ir_vote;
        nxt_state.pr_pos    = below_vote;
        nxt_state.pr_neg    = below_vote;
        // high-1 bypass raises the effective trip to the high-2 level
        nxt_state.lin_trip  = nxt_state.hi1_lin ? lin_hi2_exceed
                                                : lin_hi1_exceed;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff.ir_perm   <= VOTE_RST;
            state_ff.lin_above <= VOTE_RST;
            state_ff.lin_below <= VOTE_RST;
            state_ff.src_count <= BYPASS_RST;
            state_ff.src_rate  <= BYPASS_RST;
            state_ff.hi1_lin   <= BYPASS_RST;
            state_ff.ir_rate   <= BYPASS_RST;
            state_ff.dw_scm    <= BYPASS_RST;
            state_ff.pr_pos    <= BYPASS_RST;
            state_ff.pr_neg    <= BYPASS_RST;
            state_ff.lin_trip  <= TRIP_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign ir_permissive                          = state_ff.ir_perm;
    assign ir_interlock                           = state_ff.ir_perm;
    assign linear_power_above_vote                = state_ff.lin_above;
    assign linear_power_below_vote                = state_ff.lin_below;
    assign byp_src_count_trip                     = state_ff.src_count;
    assign byp_src_rate_trip                      = state_ff.src_rate;
    assign byp_hi1_lin_trip                       = state_ff.hi1_lin;
    assign byp_ir_rate_trip                       = state_ff.ir_rate;
    assign byp_dw_isol_subcritical_multiplication = state_ff.dw_scm;
    assign byp_pr_pos_rate_trip                   = state_ff.pr_pos;
    assign byp_pr_neg_rate_trip                   = state_ff.pr_neg;
    assign lin_high_trip                          = state_ff.lin_trip;

    // checks: input to output latency is two edges, one edge from the setpoint comparisons to lin_high_trip
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic ir_met;
    logic above_met;
    logic below_met;

    always_comb begin
        ir_met    = ($countones(ir_above_decade) >= NEED);
        above_met = ($countones(pr_above_15pct) >= NEED);
        below_met = ($countones(pr_below_15pct) >= NEED);
    end

    a_ir_perm_vote: assert property (
        ##1 ir_met |-> ##2 ir_permissive == 1'b1
    ) else $error("permissive missing after 3 of 4 above");

    a_ir_perm_drop: assert property (
        ##1 !ir_met |-> ##2 !ir_permissive
    ) else $error("permissive held without vote");

    // a single-cycle operator pulse is enough once the vote is up
    a_src_byp_grant: assert property (
        ##1 ir_met ##1 (ir_met && src_count_byp_req) |-> ##2 byp_src_count_trip
    ) else $error("source count bypass not granted");

    a_src_rate_grant: assert property (
        ##1 ir_met ##1 (ir_met && src_rate_byp_req) |-> ##2 byp_src_rate_trip
    ) else $error("source rate bypass not granted");

    // a request made while the vote was down must not survive its return
    a_src_byp_refuse: assert property (
        ##1 !ir_met ##1 (ir_met && !src_count_byp_req && !src_rate_byp_req)
            ##1 (!src_count_byp_req && !src_rate_byp_req)
            |-> ##2 (!byp_src_count_trip && !byp_src_rate_trip)
    ) else $error("source bypass remembered without permissive");

    a_src_byp_clear: assert property (
        ##1 (ir_byp_clr && !src_count_byp_req && !src_rate_byp_req)
            |-> ##2 (!byp_src_count_trip && !byp_src_rate_trip)
    ) else $error("source bypass survived clear");

    a_manual_byp_removal: assert property (
        ##1 !ir_met |-> ##2 (!byp_src_count_trip && !byp_src_rate_trip)
    ) else $error("manual bypass outlived permissive");

    a_dw_scm_auto: assert property (
        ##1 ir_met |-> ##2 byp_dw_isol_subcritical_multiplication
    ) else $error("water isolation bypass missing");

    a_dw_scm_drop: assert property (
        ##1 !ir_met |-> ##2 (!byp_dw_isol_subcritical_multiplication && !ir_interlock)
    ) else $error("water isolation bypass outlived interlock");

    a_auto_byp_follow: assert property (
        ##1 !below_met |-> ##2 (!byp_pr_pos_rate_trip && !byp_pr_neg_rate_trip)
    ) else $error("rate trip bypass outlived interlock");

    a_lin_perm_vote: assert property (
        ##1 above_met |-> ##2 (linear_power_above_vote && byp_ir_rate_trip)
    ) else $error("linear permissive or rate bypass missing");

    a_lin_byp_removal: assert property (
        ##1 !above_met |-> ##2 (!linear_power_above_vote && !byp_hi1_lin_trip && !byp_ir_rate_trip)
    ) else $error("linear bypasses outlived their vote");

    a_hi1_byp_gate: assert property (
        byp_hi1_lin_trip |-> linear_power_above_vote
    ) else $error("high-1 bypass without linear permissive");

    a_lin_byp_grant: assert property (
        ##1 above_met ##1 (above_met && hi1_lin_byp_req) |-> ##2 byp_hi1_lin_trip
    ) else $error("high-1 bypass not granted");

    a_hi2_setpoint: assert property (
        ##1 $past(nxt_state.hi1_lin) |->
            lin_high_trip == $past(lin_hi2_exceed)
    ) else $error("high-2 setpoint not used when bypassed");

    a_hi1_setpoint: assert property (
        ##2 !$past(nxt_state.hi1_lin) |->
            lin_high_trip == $past(lin_hi1_exceed)
    ) else $error("high-1 setpoint not used without bypass");

    a_low_power_vote: assert property (
        ##1 below_met |-> ##2 (linear_power_below_vote
                               && byp_pr_pos_rate_trip && byp_pr_neg_rate_trip)
    ) else $error("low-power interlock bypasses missing");

    c_src_bypass: cover property (
        byp_src_count_trip ##1 !ir_permissive
    );

    c_hi2_active: cover property (
        byp_hi1_lin_trip && lin_high_trip
    );

    c_low_power: cover property (
        byp_pr_pos_rate_trip ##[1:20] byp_ir_rate_trip
    );

    c_lin_clear: cover property (
        byp_hi1_lin_trip ##1 (!byp_hi1_lin_trip && linear_power_above_vote)
    );

endmodule

/* hdl/vote_pkg.sv */
/*
 * constants shared by the neutron-power permissive and interlock voter.
 * assumes every channel comparison arrives as a boolean synchronous to ref_clk.
 */
package vote_pkg;

    // redundant channels and coincidence needed
    localparam int CHAN_COUNT = 4;
    localparam int VOTE_NEED  = 3;

    // documented thresholds, kept for reference by the comparators upstream
    localparam int IR_DECADES_ABOVE_LRL = 1;
    localparam int LIN_POWER_PCT_RTP    = 15;

    // reset values
    localparam logic VOTE_RST   = 1'b0;
    localparam logic BYPASS_RST = 1'b0;
    localparam logic TRIP_RST   = 1'b0;

    // bit positions of the operator request vectors
    localparam int IR_BYP_SRC_COUNT = 0;
    localparam int IR_BYP_SRC_RATE  = 1;
    localparam int LIN_BYP_HI1      = 0;
    localparam int LIN_BYP_IR_RATE  = 1;
    localparam int BYP_PER_PERMIT   = 2;

endpackage

/* sim/channel_bank.sv */
/*
 * model of four redundant instrument channels feeding one threshold comparison.
 * assumes the bench sets how many channels are over threshold and a rotation,
 * changing both just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module channel_bank (
    // channel scene
    input  wire logic [2:0] n_high,
    input  wire logic [1:0] rot,
    // per-channel comparison results
    output logic      [3:0] chan
);
    logic [4:0] base;
    logic [7:0] dbl;

    // rotation moves the set channels around so no single channel index is favoured
    always_comb begin
        base = (5'h01 << n_high) - 5'h01;
        dbl  = {base[3:0], base[3:0]} << rot;
        chan = dbl[7:4];
    end
endmodule

/* sim/testbench.sv */
/*
 * self-checking bench for the neutron-power permissive and interlock voter.
 * assumes the design's two-edge latency from channel and operator inputs to outputs and synchronous reset.
 */
`timescale 1ns/1ps
module testbench;
    import vote_pkg::*;

    logic        ref_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic [2:0]  ir_n       = 3'h0;
    logic [2:0]  ab_n       = 3'h0;
    logic [2:0]  bl_n       = 3'h0;
    logic [1:0]  rot        = 2'h0;
    logic        hi1        = 1'b0;
    logic        hi2        = 1'b0;
    logic [5:0]  ctl        = 6'h00;
    logic [3:0]  ir_vec;
    logic [3:0]  ab_vec;
    logic [3:0]  bl_vec;
    logic [11:0] outs;
    logic        b_sc       = 1'b0;
    logic        b_sr       = 1'b0;
    logic        b_h1       = 1'b0;
    logic        b_irm      = 1'b0;
    int          n_errors   = 0;
    int          n_compared = 0;

    always #25 ref_clk = ~ref_clk;

    channel_bank ir_bank (.n_high(ir_n), .rot(rot), .chan(ir_vec));
    channel_bank ab_bank (.n_high(ab_n), .rot(rot), .chan(ab_vec));
    channel_bank bl_bank (.n_high(bl_n), .rot(rot), .chan(bl_vec));

    power_interlock_permissive_voter power_interlock_permissive_voter_i (
        .ref_clk                               (ref_clk),
        .rst                                   (rst),
        .ir_above_decade                       (ir_vec),
        .pr_above_15pct                        (ab_vec),
        .pr_below_15pct                        (bl_vec),
        .lin_hi1_exceed                        (hi1),
        .lin_hi2_exceed                        (hi2),
        .src_count_byp_req                     (ctl[5]),
        .src_rate_byp_req                      (ctl[4]),
        .ir_byp_clr                            (ctl[3]),
        .hi1_lin_byp_req                       (ctl[2]),
        .ir_rate_byp_req                       (ctl[1]),
        .lin_byp_clr                           (ctl[0]),
        .ir_permissive                         (outs[11]),
        .ir_interlock                          (outs[10]),
        .linear_power_above_vote               (outs[9]),
        .linear_power_below_vote               (outs[8]),
        .byp_src_count_trip                    (outs[7]),
        .byp_src_rate_trip                     (outs[6]),
        .byp_hi1_lin_trip                      (outs[5]),
        .byp_ir_rate_trip                      (outs[4]),
        .byp_dw_isol_subcritical_multiplication(outs[3]),
        .byp_pr_pos_rate_trip                  (outs[2]),
        .byp_pr_neg_rate_trip                  (outs[1]),
        .lin_high_trip                         (outs[0])
    );

    // expected outputs from channel counts and the bench's own bypass bookkeeping
    function automatic logic [11:0] expv();
        logic ir;
        logic ab;
        logic bl;
        ir = (ir_n >= 3'h3);
        ab = (ab_n >= 3'h3);
        bl = (bl_n >= 3'h3);
        return {ir, ir, ab, bl, b_sc, b_sr, b_h1, b_irm | ab, ir, bl, bl, b_h1 ? hi2 : hi1};
    endfunction

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // new channel scene; losing a vote drops the bypasses held under it
    task automatic vote(input logic [2:0] i, input logic [2:0] a, input logic [2:0] b,
                        input logic h1, input logic h2);
        @(posedge ref_clk);
        ir_n <= i;
        ab_n <= a;
        bl_n <= b;
        hi1  <= h1;
        hi2  <= h2;
        if (i < 3'h3) begin
            b_sc = 1'b0;
            b_sr = 1'b0;
        end
        if (a < 3'h3) begin
            b_h1  = 1'b0;
            b_irm = 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // one-cycle operator pulse; ignored while its permissive is down, request beats clear
    task automatic op(input logic [5:0] v);
        if (ir_n >= 3'h3) begin
            b_sc = v[5] | (b_sc & ~v[3]);
            b_sr = v[4] | (b_sr & ~v[3]);
        end
        if (ab_n >= 3'h3) begin
            b_h1  = v[2] | (b_h1 & ~v[0]);
            b_irm = v[1] | (b_irm & ~v[0]);
        end
        @(posedge ref_clk);
        ctl <= v;
        @(posedge ref_clk);
        ctl <= 6'h00;
        @(posedge ref_clk);
        #1;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        chk(outs, 12'h000);
        @(posedge ref_clk);
        rst <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            // rotation moves on an edge like every other input
            @(posedge ref_clk);
            rot <= 2'(r);
            for (int n = 0; n <= 4; n++) begin
                vote(3'(n), 3'(n), 3'(4 - n), 1'b1, 1'b0);
                chk(outs, expv());
            end
        end
        // requests under a missing permissive must not be remembered
        vote(3'h2, 3'h0, 3'h4, 1'b0, 1'b0);
        op(6'h30);
        chk(outs, expv());
        vote(3'h3, 3'h0, 3'h4, 1'b0, 1'b0);
        chk(outs, expv());
        op(6'h20);
        chk(outs, expv());
        op(6'h10);
        chk(outs, expv());
        op(6'h08);
        chk(outs, expv());
        op(6'h28);
        chk(outs, expv());
        op(6'h10);
        vote(3'h2, 3'h0, 3'h4, 1'b0, 1'b0);
        chk(outs, expv());
        // linear power side with setpoint selection
        vote(3'h0, 3'h3, 3'h0, 1'b1, 1'b0);
        chk(outs, expv());
        op(6'h04);
        chk(outs, expv());
        vote(3'h0, 3'h4, 3'h0, 1'b0, 1'b1);
        chk(outs, expv());
        op(6'h02);
        chk(outs, expv());
        op(6'h01);
        chk(outs, expv());
        op(6'h06);
        vote(3'h0, 3'h2, 3'h1, 1'b1, 1'b0);
        chk(outs, expv());
        op(6'h04);
        chk(outs, expv());
        end_of_test();
    end
endmodule
